// ==== design/csr_regs.svh ====
// Purpose: Offsets, field positions, reset values and scale constants of the charge setpoint bank
// Assumes: Included by bare name from the package-using design files
// Notes:   Currents in mA, voltages in mV
`ifndef CSR_REGS_SVH
`define CSR_REGS_SVH

// ----------------------------------------------------------------------
// Bus address and register offsets
// ----------------------------------------------------------------------
`define CSR_DEV_ADDR 7'h6B
`define CSR_OFS_CHG_CUR 8'h02
`define CSR_OFS_PRE_TERM 8'h03
`define CSR_OFS_CHG_VOLT 8'h04
`define CSR_OFS_LAST_RW 8'h07

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CSR_RST_CHG_CUR 8'h60
`define CSR_RST_PRE_TERM 8'h11
`define CSR_RST_CHG_VOLT 8'hB2
`define CSR_RST_OTHER 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CSR_FAST_MSB 7
`define CSR_FAST_LSB 2
`define CSR_RSVD_BIT 1
`define CSR_REDUCE_BIT 0
`define CSR_PRE_MSB 7
`define CSR_PRE_LSB 4
`define CSR_TERM_MSB 3
`define CSR_TERM_LSB 0
`define CSR_CHARGE_VOLTAGE_TARGET_MSB 7
`define CSR_CHARGE_VOLTAGE_TARGET_LSB 2
`define CSR_EXIT_BIT 1
`define CSR_RECH_BIT 0

// ----------------------------------------------------------------------
// Scaling
// ----------------------------------------------------------------------
`define CSR_FAST_OFS_MA 13'h0200
`define CSR_FAST_LSB_MA 13'h0040
`define CSR_PRE_OFS_MA 12'h080
`define CSR_PRE_LSB_MA 12'h080
`define CSR_CHARGE_VOLTAGE_TARGET_OFS_MV 13'h0DB0
`define CSR_CHARGE_VOLTAGE_TARGET_LSB_MV 13'h0010
`define CSR_CHARGE_VOLTAGE_TARGET_MAX_CODE 6'h38
`define CSR_EXIT_LO_MV 12'hAF0
`define CSR_EXIT_HI_MV 12'hBB8
`define CSR_RECH_LO_MV 9'h064
`define CSR_RECH_HI_MV 9'h12C
`define CSR_PCT_NUM 13'h0014
`define CSR_PCT_DEN 13'h0064

`endif

// ==== design/csr_pkg.sv ====
// Purpose: Types shared by the charge setpoint bank
// Assumes: Nothing beyond the constants header
// Notes:   Setpoints travel together as one packed struct
package csr_pkg;
   typedef struct packed {
      logic [12:0] fast_charge_current;
      logic [11:0] precondition_current;
      logic [11:0] termination_current;
      logic [12:0] charge_voltage_target;
      logic [11:0] precondition_exit_threshold;
      logic [8:0] recharge_hysteresis;
   } csr_setpoint_t;

   typedef enum logic [1:0] {
      CSR_PH_IDLE,
      CSR_PH_ADDR,
      CSR_PH_DATA
   } csr_phase_t;
endpackage

// ==== design/csr_i2c_slave.sv ====
// Purpose: I2C target front end: byte engine on synchronised SCL/SDA
// Assumes: Bus rate well below 1/4 of the system clock
// Notes:   Register pointer auto-increments after each data byte
`timescale 1ns/1ps
`include "csr_regs.svh"
module csr_i2c_slave
   import csr_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic wr_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   input wire logic [7:0] rdata_i
);
   logic [1:0] scl_s_r;
   logic [1:0] sda_s_r;
   logic scl_d_r;
   logic sda_d_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic rd_mode_r;
   logic ack_r;
   logic selected_r;
   csr_phase_t phase_r;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;

   // ----------------------------------------------------------------------
   // Synchronisers: the second stage and its one-clock delayed copy feed logic; the first stage does not
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         scl_s_r <= 2'b11;
         sda_s_r <= 2'b11;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_s_r <= {scl_s_r[0], scl_i};
         sda_s_r <= {sda_s_r[0], sda_i};
         scl_d_r <= scl_s_r[1];
         sda_d_r <= sda_s_r[1];
      end
   end

   // Bus conditions
   assign scl_rise = scl_s_r[1] & ~scl_d_r;
   assign scl_fall = ~scl_s_r[1] & scl_d_r;
   assign start_c = scl_s_r[1] & scl_d_r & ~sda_s_r[1] & sda_d_r;
   assign stop_c = scl_s_r[1] & scl_d_r & sda_s_r[1] & ~sda_d_r;

   // ----------------------------------------------------------------------
   // Byte engine: bits 0..7 data, bit 8 is the acknowledge slot
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         rd_mode_r <= 1'b0;
         ack_r <= 1'b0;
         selected_r <= 1'b0;
         phase_r <= CSR_PH_IDLE;
         addr_o <= 8'h00;
         wdata_o <= 8'h00;
         wr_o <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         wr_o <= 1'b0;
         // Pointer steps the cycle after a write strobe, so the write lands first
         if (wr_o) begin
            addr_o <= addr_o + 8'h01;
         end
         if (start_c) begin
            bit_cnt_r <= 4'h0;
            selected_r <= 1'b1;
            phase_r <= CSR_PH_IDLE;
            rd_mode_r <= 1'b0;
            sda_oe_o <= 1'b0;
         end else if (stop_c) begin
            selected_r <= 1'b0;
            sda_oe_o <= 1'b0;
         end else if (selected_r && scl_rise && bit_cnt_r < 4'h8) begin
            shift_r <= {shift_r[6:0], sda_s_r[1]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
         end else if (selected_r && scl_rise) begin
            // Master NACK ends a read burst
            if (rd_mode_r && sda_s_r[1]) begin
               selected_r <= 1'b0;
            end
            bit_cnt_r <= 4'h0;
         end else if (selected_r && scl_fall) begin
            if (bit_cnt_r == 4'h8 && !rd_mode_r) begin
               ack_r <= 1'b1;
               unique case (phase_r)
                  CSR_PH_IDLE: begin
                     if (shift_r[7:1] == `CSR_DEV_ADDR) begin // R8
                        rd_mode_r <= shift_r[0];
                        phase_r <= CSR_PH_ADDR;
                        if (shift_r[0]) begin
                           // First read byte is fetched now; pointer moves past it
                           shift_r <= rdata_i;
                           addr_o <= addr_o + 8'h01;
                        end
                     end else begin
                        ack_r <= 1'b0;
                        selected_r <= 1'b0;
                     end
                  end
                  CSR_PH_ADDR: begin
                     addr_o <= shift_r;
                     phase_r <= CSR_PH_DATA;
                  end
                  CSR_PH_DATA: begin
                     wdata_o <= shift_r;
                     wr_o <= 1'b1;
                  end
               endcase
               sda_o <= 1'b0;
               sda_oe_o <= (phase_r != CSR_PH_IDLE) || (shift_r[7:1] == `CSR_DEV_ADDR);
            end else if (bit_cnt_r == 4'h0 && ack_r && !rd_mode_r) begin
               // Release after the acknowledge slot
               ack_r <= 1'b0;
               sda_oe_o <= 1'b0;
            end else if (rd_mode_r) begin
               // Drive read data MSB first; release for the master acknowledge
               if (bit_cnt_r == 4'h0) begin
                  if (ack_r) begin
                     ack_r <= 1'b0;
                  end else begin
                     addr_o <= addr_o + 8'h01;
                     shift_r <= rdata_i;
                  end
                  sda_o <= ack_r ? shift_r[7] : rdata_i[7];
                  sda_oe_o <= ~(ack_r ? shift_r[7] : rdata_i[7]);
               end else if (bit_cnt_r < 4'h8) begin
                  sda_o <= 1'b0;
                  sda_oe_o <= ~shift_r[7];
               end else begin
                  sda_oe_o <= 1'b0;
               end
            end
         end
      end
   end
endmodule

// ==== design/csr_charge_setpoints.sv ====
// Purpose: Charge setpoint register bank reached over I2C
// Assumes: SCL/SDA arrive from pins; open-drain SDA resolved outside
// Notes:   Bank offsets 0x02..0x04 are decoded; 0x00..0x07 all store and read back
// Contract
// R1: Fast current 512mA plus 64mA steps
// R2: Bit 0 set charges at 20 percent
// R3: Precondition current 128mA offset, 128mA steps
// R4: Termination current 128mA offset, 128mA steps
// R5: Voltage 3.504V plus 16mV, max code 111000
// R6: Bit 1 picks 2.8V or 3.0V exit
// R7: Bit 0 picks 100mV or 300mV recharge
// R8: Address 6B; registers 0..7 read/write
// R9: Reserved current bit reads zero
`timescale 1ns/1ps
`include "csr_regs.svh"
module csr_charge_setpoints
   import csr_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output csr_setpoint_t setpoint_o,
   output logic [7:0] charge_current_control_o,
   output logic [7:0] precharge_termination_current_o,
   output logic [7:0] charge_voltage_control_o
);
   logic wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] chg_cur_r;
   logic [7:0] pre_term_r;
   logic [7:0] chg_volt_r;
   logic [7:0] other_r [0:7];
   logic [12:0] fast_full;
   logic [12:0] fast_nxt;
   logic [5:0] vcode;

   // ----------------------------------------------------------------------
   // Serial front end
   // ----------------------------------------------------------------------
   csr_i2c_slave u_slave (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe_o(sda_oe_o),
      .wr_o(wr),
      .addr_o(addr),
      .wdata_o(wdata),
      .rdata_i(rdata)
   );

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   // Bank registers; reserved bit is never stored
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         chg_cur_r <= `CSR_RST_CHG_CUR;
         pre_term_r <= `CSR_RST_PRE_TERM;
         chg_volt_r <= `CSR_RST_CHG_VOLT;
      end else if (wr) begin
         if (addr == `CSR_OFS_CHG_CUR) begin
            chg_cur_r <= wdata & ~(8'h01 << `CSR_RSVD_BIT); // R9
         end
         if (addr == `CSR_OFS_PRE_TERM) begin
            pre_term_r <= wdata;
         end
         if (addr == `CSR_OFS_CHG_VOLT) begin
            chg_volt_r <= wdata;
         end
      end
   end

   // Other offsets up to 0x07 keep plain storage so the host sees read/write
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_other
         always_ff @(posedge clock_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               other_r[gi] <= `CSR_RST_OTHER;
            end else if (wr && addr == 8'(gi)) begin
               other_r[gi] <= wdata; // R8
            end
         end
      end
   endgenerate

   // Read mux; beyond 0x07 reads zero
   always_comb begin
      if (addr == `CSR_OFS_CHG_CUR) begin
         rdata = chg_cur_r;
      end else if (addr == `CSR_OFS_PRE_TERM) begin
         rdata = pre_term_r;
      end else if (addr == `CSR_OFS_CHG_VOLT) begin
         rdata = chg_volt_r;
      end else if (addr <= `CSR_OFS_LAST_RW) begin
         rdata = other_r[addr[2:0]]; // R8
      end else begin
         rdata = 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // Setpoint decode
   // ----------------------------------------------------------------------
   // Codes above the top valid voltage code clamp to it, a safety trade-off
   assign vcode = (chg_volt_r[`CSR_CHARGE_VOLTAGE_TARGET_MSB:`CSR_CHARGE_VOLTAGE_TARGET_LSB] > `CSR_CHARGE_VOLTAGE_TARGET_MAX_CODE) ?
                  `CSR_CHARGE_VOLTAGE_TARGET_MAX_CODE : chg_volt_r[`CSR_CHARGE_VOLTAGE_TARGET_MSB:`CSR_CHARGE_VOLTAGE_TARGET_LSB]; // R5
   assign fast_full = `CSR_FAST_OFS_MA +
                      13'(chg_cur_r[`CSR_FAST_MSB:`CSR_FAST_LSB]) * `CSR_FAST_LSB_MA; // R1
   // Reduced mode divides the full value, truncating toward zero
   // Product is widened first: full scale times twenty overflows 13 bits
   assign fast_nxt = chg_cur_r[`CSR_REDUCE_BIT] ?
                     13'((17'(fast_full) * 17'(`CSR_PCT_NUM)) /
                         17'(`CSR_PCT_DEN)) : fast_full; // R2

   // Registered setpoints keep analogue loops free of decode glitches
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         setpoint_o <= '0;
      end else begin
         setpoint_o.fast_charge_current <= fast_nxt;
         setpoint_o.precondition_current <= `CSR_PRE_OFS_MA +
            12'(pre_term_r[`CSR_PRE_MSB:`CSR_PRE_LSB]) * `CSR_PRE_LSB_MA; // R3
         setpoint_o.termination_current <= `CSR_PRE_OFS_MA +
            12'(pre_term_r[`CSR_TERM_MSB:`CSR_TERM_LSB]) * `CSR_PRE_LSB_MA; // R4
         setpoint_o.charge_voltage_target <= `CSR_CHARGE_VOLTAGE_TARGET_OFS_MV +
            13'(vcode) * `CSR_CHARGE_VOLTAGE_TARGET_LSB_MV; // R5
         setpoint_o.precondition_exit_threshold <= chg_volt_r[`CSR_EXIT_BIT] ?
            `CSR_EXIT_HI_MV : `CSR_EXIT_LO_MV; // R6
         setpoint_o.recharge_hysteresis <= chg_volt_r[`CSR_RECH_BIT] ?
            `CSR_RECH_HI_MV : `CSR_RECH_LO_MV; // R7
      end
   end

   // Raw register views
   assign charge_current_control_o = chg_cur_r;
   assign precharge_termination_current_o = pre_term_r;
   assign charge_voltage_control_o = chg_volt_r;
endmodule

// ==== verif/csr_setpoint_checker.sv ====
// Purpose: Port assertions for the charge setpoint bank
// Assumes: Bound to csr_charge_setpoints
// Notes:   Setpoints trail their register by one clock
`timescale 1ns/1ps
module csr_setpoint_checker
   import csr_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire csr_setpoint_t setpoint_o,
   input wire logic [7:0] charge_current_control_o,
   input wire logic [7:0] precharge_termination_current_o,
   input wire logic [7:0] charge_voltage_control_o
);
   // ----------------------------------------
   // Reference scaling
   // ----------------------------------------
   function automatic int fast_ma(input logic [7:0] r);
      int v;
      v = 512 + r[7:2] * 64;
      return r[0] ? v * 20 / 100 : v; // Truncates, as the bank does
   endfunction
   function automatic int charge_voltage_target_mv(input logic [7:0] r);
      return 3504 + ((r[7:2] > 6'h38) ? 56 : r[7:2]) * 16; // Clamped above top code
   endfunction
   default clocking @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   // The reset guard skips the edge where the setpoint is still being loaded
   a_fast_current: assert property (
      $past(reset_n_i) && $stable(charge_current_control_o)
      |-> setpoint_o.fast_charge_current == fast_ma(charge_current_control_o))
      else $error("fast current mismatch");
   a_pre_current: assert property (
      $past(reset_n_i) && $stable(precharge_termination_current_o)
      |-> setpoint_o.precondition_current == 128 + precharge_termination_current_o[7:4] * 128)
      else $error("precondition current mismatch");
   a_term_current: assert property (
      $past(reset_n_i) && $stable(precharge_termination_current_o)
      |-> setpoint_o.termination_current == 128 + precharge_termination_current_o[3:0] * 128)
      else $error("termination current mismatch");
   a_volt_target: assert property (
      $past(reset_n_i) && $stable(charge_voltage_control_o)
      |-> setpoint_o.charge_voltage_target == charge_voltage_target_mv(charge_voltage_control_o))
      else $error("voltage target mismatch");
   a_exit_thresh: assert property ($changed(charge_voltage_control_o) |-> ##2
      setpoint_o.precondition_exit_threshold == (charge_voltage_control_o[1] ? 3000 : 2800))
      else $error("exit threshold mismatch");
   a_rech_hyst: assert property ($changed(charge_voltage_control_o) |-> ##2
      setpoint_o.recharge_hysteresis == (charge_voltage_control_o[0] ? 300 : 100))
      else $error("recharge hysteresis mismatch");
   a_rsvd_zero: assert property (charge_current_control_o[1] == 1'b0)
      else $error("reserved bit set");
   a_sda_low_clk: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data line moved while clock high");
   a_open_drain: assert property (sda_oe_o |-> sda_o == 1'b0)
      else $error("data line driven high");
endmodule
bind csr_charge_setpoints csr_setpoint_checker u_checker (.clock_i, .reset_n_i, .scl_i,
   .sda_i, .sda_o, .sda_oe_o, .setpoint_o, .charge_current_control_o,
   .precharge_termination_current_o, .charge_voltage_control_o);

// ==== verif/csr_host_model.sv ====
// Purpose: Host processor model speaking the two-wire bus
// Assumes: Clock high and low phases of ten system clocks
// Notes:   Moves the data line while the bus clock is low, except in start and stop
`timescale 1ns/1ps
`include "csr_regs.svh"
module csr_host_model (
   input wire logic clock_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   // Start or repeated start; releases data first so it can fall while clock is high
   task automatic start;
      sda_oe_o = 1'b0;
      w(5);
      scl_o = 1'b1;
      w(10);
      sda_oe_o = 1'b1;
      w(10);
      scl_o = 1'b0;
      w(5);
   endtask
   task automatic stop;
      sda_oe_o = 1'b1;
      w(5);
      scl_o = 1'b1;
      w(10);
      sda_oe_o = 1'b0;
      w(10);
   endtask
   task automatic bit_x(input logic b, output logic s);
      sda_oe_o = !b;
      w(5);
      scl_o = 1'b1;
      w(5);
      s = sda_i;
      w(5);
      scl_o = 1'b0;
      w(5);
   endtask
   // Eight bits, most significant first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic nak);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], s);
         q = {q[6:0], s};
      end
      bit_x(last, nak);
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d0,
                     input logic [7:0] d1, input int n, output logic nak);
      logic [7:0] q;
      logic a;
      start;
      xfer({dev, 1'b0}, 1'b1, q, nak);
      if (!nak) begin
         xfer(ptr, 1'b1, q, a);
         nak |= a;
         xfer(d0, 1'b1, q, a);
         nak |= a;
         if (n > 1) begin
            xfer(d1, 1'b1, q, a);
            nak |= a;
         end
      end
      stop;
   endtask
   task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
      logic [7:0] q;
      logic a;
      start;
      xfer({`CSR_DEV_ADDR, 1'b0}, 1'b1, q, a);
      xfer(ptr, 1'b1, q, a);
      start;
      xfer({`CSR_DEV_ADDR, 1'b1}, 1'b1, q, a);
      xfer(8'hff, 1'b1, d, a); // Released slot ends the read
      stop;
   endtask
endmodule

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the charge setpoint bank
// Assumes: Host model drives the bus; pull-up on the data line
// Notes:   Expected setpoints worked out from the field weights
`timescale 1ns/1ps
`include "csr_regs.svh"
module tb_top
   import csr_pkg::*;
;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic scl, host_oe, sda_o, sda_oe;
   wire sda;
   csr_setpoint_t sp;
   logic [7:0] r2, r3, r4;
   int err_count = 0;
   int check_count = 0;
   // Open drain: pull-up wins unless someone pulls low
   assign sda = !host_oe && !(sda_oe && !sda_o);
   always #25 clk = ~clk;
   csr_charge_setpoints dut (.clock_i(clk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .setpoint_o(sp), .charge_current_control_o(r2),
      .precharge_termination_current_o(r3), .charge_voltage_control_o(r4));
   csr_host_model host (.clock_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
   task automatic chk(input string nm, input logic [15:0] got, input int exp);
      check_count++;
      if (got !== 16'(exp)) begin
         err_count++;
         $display("Error %s expected %0d seen %0d", nm, exp, got);
      end
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] ptr, input int exp);
      logic [7:0] d;
      host.rd(ptr, d);
      chk(nm, d, exp);
   endtask
   task automatic close_out;
      $display("Checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog sized well beyond the ten bus transactions
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      close_out;
   end
   initial begin
      logic nak;
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      repeat (8) @(negedge clk);
      chk("charge_current_control", r2, 'h60);
      chk("reg03", r3, 'h11);
      chk("charge_voltage_control", r4, 'hb2);
      chk("fast", sp.fast_charge_current, 2048);
      chk("pre", sp.precondition_current, 256);
      chk("term", sp.termination_current, 256);
      chk("charge_voltage_target", sp.charge_voltage_target, 4208);
      chk("exit", sp.precondition_exit_threshold, 3000);
      chk("rech", sp.recharge_hysteresis, 100);
      rd_chk("rd04", 8'h04, 'hb2);
      $display("Test defaults done");
      // Reduced current, reserved bit written high
      host.wr(`CSR_DEV_ADDR, 8'h02, 8'h87, 8'h00, 1, nak);
      chk("ack", nak, 0);
      chk("charge_current_control", r2, 'h85);
      chk("fast", sp.fast_charge_current, (512 + 33 * 64) * 20 / 100);
      rd_chk("rd02", 8'h02, 'h85);
      host.wr(`CSR_DEV_ADDR, 8'h02, 8'he4, 8'h00, 1, nak);
      chk("fast", sp.fast_charge_current, 512 + 57 * 64);
      $display("Test current done");
      // Burst into two registers, voltage code above the top
      host.wr(`CSR_DEV_ADDR, 8'h03, 8'hf0, 8'hfd, 2, nak);
      chk("pre", sp.precondition_current, 128 + 15 * 128);
      chk("term", sp.termination_current, 128);
      chk("charge_voltage_target", sp.charge_voltage_target, 4400);
      chk("exit", sp.precondition_exit_threshold, 2800);
      chk("rech", sp.recharge_hysteresis, 300);
      host.wr(`CSR_DEV_ADDR, 8'h04, 8'he2, 8'h00, 1, nak);
      chk("charge_voltage_target", sp.charge_voltage_target, 3504 + 56 * 16);
      $display("Test burst done");
      // Foreign address refused; outer offsets
      host.wr(7'h6a, 8'h02, 8'h00, 8'h00, 1, nak);
      chk("nak", nak, 1);
      chk("charge_current_control", r2, 'he4);
      host.wr(`CSR_DEV_ADDR, 8'h07, 8'h5a, 8'h00, 1, nak);
      rd_chk("rd07", 8'h07, 'h5a);
      rd_chk("rd08", 8'h08, 'h00);
      $display("Test address done");
      // Reset in mid-run
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      repeat (8) @(negedge clk);
      chk("charge_current_control", r2, 'h60);
      chk("fast", sp.fast_charge_current, 2048);
      $display("Test reset done");
      close_out;
   end
endmodule
